// >>> design/wd_config_guard.sv
/*
  Watchdog configuration guard with timed unlock, APB slave and timeout.
  Assumes fuse inputs are static pins and that wd_reset_req resets the system.
*/
`timescale 1ns/1ps
module wd_config_guard #(
  parameter int TIMEOUT_CYCLES = wdt_guard_pkg::TIMEOUT_BASE
) (
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [wdt_guard_pkg::APB_AW-1:0]   paddr,
  input  wire logic [wdt_guard_pkg::APB_DW-1:0]   pwdata,
  output logic      [wdt_guard_pkg::APB_DW-1:0]   prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               legacy_compat_fuse,
  input  wire logic                               wd_always_on_fuse,
  output logic                                    wd_running,
  output logic                                    wd_reset_req
);
  import wdt_guard_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [1:0]       compat_sync_ff;
  logic [1:0]       alwayson_sync_ff;
  logic [1:0]       level_ff;
  logic             enable_ff;
  logic [SEL_W-1:0] sel_ff;
  logic [2:0]       win_cnt_ff;
  logic [3:0]       div_ff;
  logic             tick_ff;
  logic             running_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic [APB_DW-1:0] prdata_ff;
  logic             expired;
  logic             access;
  logic             wr_ctrl;
  logic             wr_restart;
  logic             win_open;
  logic             unlock_wr;
  logic             commit_wr;
  logic             en_eff;
  logic             nxt_enable;
  logic [SEL_W-1:0] nxt_sel;

  // Address decode shared by reads and writes.
  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return (a == OFS_CONTROL) || (a == OFS_RESTART) || (a == OFS_STATUS);
  endfunction : mapped

  assign access     = psel && penable && pready_ff;
  assign wr_ctrl    = access && pwrite && (paddr == OFS_CONTROL);
  assign wr_restart = access && pwrite && (paddr == OFS_RESTART);
  assign win_open   = (win_cnt_ff != 3'h0);
  assign unlock_wr  = wr_ctrl && pwdata[UNLOCK_POS] && pwdata[ENABLE_POS];
  assign commit_wr  = wr_ctrl && win_open && !pwdata[UNLOCK_POS];
  assign en_eff     = enable_ff || (level_ff == LEVEL_2);

  ////////////////////////////////////////////////////////////////////////////
  // Fuse synchronisers and safety level.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compat_sync_ff   <= 2'h0;
      alwayson_sync_ff <= 2'h0;
    end else begin
      compat_sync_ff   <= {compat_sync_ff[0], legacy_compat_fuse};
      alwayson_sync_ff <= {alwayson_sync_ff[0], wd_always_on_fuse};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level_ff <= RST_LEVEL;
    end else if (alwayson_sync_ff[1]) begin
      level_ff <= LEVEL_2;
    end else if (compat_sync_ff[1]) begin
      level_ff <= LEVEL_0;
    end else begin
      level_ff <= LEVEL_1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock window counter.
  // Four-cycle window.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      win_cnt_ff <= 3'h0;
    end else if (unlock_wr) begin
      win_cnt_ff <= WINDOW_CYCLES;
    end else if (commit_wr) begin
      win_cnt_ff <= 3'h0;
    end else if (win_open) begin
      win_cnt_ff <= win_cnt_ff - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guarded control bits.
  always_comb begin
    nxt_enable = enable_ff;
    nxt_sel    = sel_ff;
    if (commit_wr) begin
      nxt_sel = pwdata[SEL_LSB +: SEL_W];
      if (level_ff != LEVEL_2) begin
        nxt_enable = pwdata[ENABLE_POS];
      end
    end else if (wr_ctrl) begin
      if (pwdata[ENABLE_POS]) begin
        nxt_enable = 1'b1;
      end
      if (level_ff == LEVEL_0) begin
        nxt_sel = pwdata[SEL_LSB +: SEL_W];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      enable_ff <= RST_ENABLE;
      sel_ff    <= RST_SELECT;
    end else begin
      enable_ff <= nxt_enable;
      sel_ff    <= nxt_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick divider and timeout counter.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || div_ff == WD_DIV_LAST) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_ff    <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      tick_ff    <= (div_ff == WD_DIV_LAST);
      running_ff <= en_eff;
    end
  end

  wd_timeout_counter #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_counter (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .tick        (tick_ff),
    .running     (running_ff),
    .restart     (wr_restart),
    .timeout_sel (sel_ff),
    .expired_ff  (expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, answer set during setup.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (psel && !penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !mapped(paddr);
      prdata_ff  <= '0;
      if (!pwrite && paddr == OFS_CONTROL) begin
        prdata_ff[SEL_LSB +: SEL_W] <= sel_ff;
        prdata_ff[ENABLE_POS]       <= en_eff;
        prdata_ff[UNLOCK_POS]       <= win_open;
      end else if (!pwrite && paddr == OFS_STATUS) begin
        prdata_ff[1:0] <= level_ff;
        prdata_ff[2]   <= running_ff;
      end
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign wd_running   = running_ff;
  assign wd_reset_req = expired;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_ENABLE_FREE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && pwdata[ENABLE_POS] |=> en_eff)
    else $error("enable write was not accepted");

  AST_LEVEL0_SELECT: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && level_ff == LEVEL_0 |=> sel_ff == $past(pwdata[2:0]))
    else $error("level 0 select write not taken");

  AST_LEVEL1_GUARD: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && level_ff == LEVEL_1 && !win_open |=> $stable(sel_ff))
    else $error("level 1 select changed without unlock");

  AST_COMMIT: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    commit_wr |=> sel_ff == $past(pwdata[2:0]) && !win_open)
    else $error("commit write did not update select");

  AST_ALWAYS_RUN: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    level_ff == LEVEL_2 |=> wd_running)
    else $error("level 2 watchdog not running");

  AST_NO_DISABLE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    level_ff == LEVEL_2 && $past(level_ff) == LEVEL_2 |-> wd_running)
    else $error("level 2 watchdog disabled");

  AST_RESET_OFF: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !enable_ff && !win_open)
    else $error("watchdog not disabled after reset");

  AST_READ_ENABLE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    pready && !pwrite && paddr == OFS_CONTROL && $past(level_ff) == LEVEL_2
    |-> prdata[ENABLE_POS])
    else $error("level 2 enable did not read as one");

  AST_LEVEL2_GUARD: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && level_ff == LEVEL_2 && !win_open |=> $stable(sel_ff))
    else $error("level 2 select changed without unlock");

  AST_UNLOCK_OPENS: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && pwdata[UNLOCK_POS] && pwdata[ENABLE_POS]
    |=> win_cnt_ff == WINDOW_CYCLES)
    else $error("unlock write did not open the window");

  AST_LEVEL2_COMMIT: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    commit_wr && level_ff == LEVEL_2 |=> $stable(enable_ff))
    else $error("level 2 commit changed the enable bit");

  AST_EXPIRY_TICK: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    expired |-> $past(tick_ff) && $past(running_ff))
    else $error("expiry without a running tick");

  AST_UNLOCK_NEEDS_EN: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && !pwdata[ENABLE_POS] && !win_open |=> !win_open)
    else $error("window opened without enable bit");

  AST_WINDOW_LEN: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    unlock_wr ##1 !wr_ctrl [*4] |=> !win_open)
    else $error("unlock window longer than four cycles");

  AST_LEVEL_FUSE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    alwayson_sync_ff[1] |=> level_ff == LEVEL_2)
    else $error("always-on fuse did not give level 2");

  AST_OUTSIDE_WINDOW: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && !win_open && !pwdata[ENABLE_POS] |=> $stable(enable_ff))
    else $error("enable cleared outside window");

endmodule : wd_config_guard

// >>> design/wdt_guard_pkg.sv
/*
  Shared constants for the watchdog configuration guard: register offsets,
  field positions, reset values, safety level codes and timing counts.
  Assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
package wdt_guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map.
  localparam int          APB_AW         = 8;
  localparam int          APB_DW         = 32;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_RESTART    = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields.
  localparam int          SEL_LSB        = 0;
  localparam int          SEL_W          = 3;
  localparam int          ENABLE_POS     = 3;
  localparam int          UNLOCK_POS     = 4;
  localparam logic [2:0]  RST_SELECT     = 3'h0;
  localparam logic        RST_ENABLE     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Safety levels.
  localparam logic [1:0]  LEVEL_0        = 2'h0;
  localparam logic [1:0]  LEVEL_1        = 2'h1;
  localparam logic [1:0]  LEVEL_2        = 2'h2;
  localparam logic [1:0]  RST_LEVEL      = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam logic [2:0]  WINDOW_CYCLES  = 3'h4;
  localparam int          SYS_CLK_HZ     = 10_000_000;
  localparam int          WD_OSC_HZ      = 1_000_000;
  localparam int          WD_OSC_DIV     = SYS_CLK_HZ / WD_OSC_HZ;
  localparam logic [3:0]  WD_DIV_LAST    = 4'(WD_OSC_DIV - 1);
  localparam int          TIMEOUT_BASE   = 16_384;
  localparam int          TIMEOUT_W      = 22;

endpackage : wdt_guard_pkg

// >>> design/wd_timeout_counter.sv
/*
  Watchdog timeout counter. Counts oscillator ticks while enabled and raises
  a one-cycle expiry pulse when the selected timeout elapses.
  Assumes tick is a one-cycle enable pulse on the same clock.
*/
`timescale 1ns/1ps
module wd_timeout_counter #(
  parameter int TIMEOUT_CYCLES = wdt_guard_pkg::TIMEOUT_BASE
) (
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  input  wire logic                               tick,
  input  wire logic                               running,
  input  wire logic                               restart,
  input  wire logic [wdt_guard_pkg::SEL_W-1:0]    timeout_sel,
  output logic                                    expired_ff
);
  import wdt_guard_pkg::*;

  logic [TIMEOUT_W-1:0] count_ff;
  logic [TIMEOUT_W-1:0] limit;

  // Timeout doubles with each select step.
  assign limit = TIMEOUT_W'(TIMEOUT_CYCLES) << timeout_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Selectable timeout count.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running || restart || expired_ff) begin
      count_ff <= '0;
    end else if (tick) begin
      count_ff <= count_ff + TIMEOUT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= running && !restart && !expired_ff && tick &&
                    (count_ff == limit - TIMEOUT_W'(1));
    end
  end

endmodule : wd_timeout_counter

// >>> bench/testbench.sv
/*
  Self-checking bench for the watchdog configuration guard.
  Assumes the guard package is compiled first and a 10 MHz system clock.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  fails++; $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
  import wdt_guard_pkg::*;

  logic              sys_clk;
  logic              sys_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              legacy_compat_fuse;
  logic              wd_always_on_fuse;
  logic              wd_running;
  logic              wd_reset_req;
  logic [31:0]       rdata;
  logic              rerr;
  logic [2:0]        exp_sel;
  logic              exp_en;
  logic [1:0]        lvl;
  logic [2:0]        c;
  int                fails;
  int                n_compared;
  int                k;
  int                t;

  localparam int     TB_TIMEOUT = 4;

  wd_config_guard #(.TIMEOUT_CYCLES(TB_TIMEOUT)) u_wd_config_guard (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .legacy_compat_fuse (legacy_compat_fuse),
    .wd_always_on_fuse  (wd_always_on_fuse),
    .wd_running         (wd_running),
    .wd_reset_req       (wd_reset_req)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer, entered and left just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("[FAIL] t=%0t no pready", $time);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Reads the control word and compares it with the bench's model.
  task automatic chk_ctrl();
    apb(1'b0, OFS_CONTROL, 32'h0);
    `CHK(rdata, {27'h0, 1'b0, exp_en, exp_sel})
  endtask : chk_ctrl

  function automatic logic [1:0] lvl_of(input logic cf, input logic af);
    return af ? LEVEL_2 : (cf ? LEVEL_0 : LEVEL_1);
  endfunction : lvl_of

  // System clock cycles from restart to expiry for one select code.
  function automatic int timeout_sys(input logic [2:0] s);
    return WD_OSC_DIV * (TB_TIMEOUT << s);
  endfunction : timeout_sys

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: every fuse combination, then each guarded path.
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    legacy_compat_fuse = 1'b0;
    wd_always_on_fuse = 1'b0;
    fails = 0;
    n_compared = 0;
    void'($urandom(74662));
    for (int f = 0; f < 4; f++) begin
      sys_rst <= 1'b1;
      legacy_compat_fuse <= f[0];
      wd_always_on_fuse  <= f[1];
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      lvl = lvl_of(f[0], f[1]);
      exp_sel = 3'h0;
      exp_en = (lvl == LEVEL_2);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rdata[1:0], lvl)
      chk_ctrl();
      c = 3'($urandom % 8);
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b01, c});
      exp_en = 1'b1;
      if (lvl == LEVEL_0) exp_sel = c;
      chk_ctrl();
      c = 3'($urandom % 8);
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, c});
      if (lvl == LEVEL_0) exp_sel = c;
      chk_ctrl();
      c = 3'($urandom % 8);
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b11, exp_sel});
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, c});
      exp_sel = c;
      exp_en = (lvl == LEVEL_2);
      chk_ctrl();
      `CHK(wd_running, exp_en)
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b01, exp_sel});
      exp_en = 1'b1;
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b11, exp_sel});
      repeat (6) @(posedge sys_clk);
      chk_ctrl();
      c = ~exp_sel;
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, c});
      if (lvl == LEVEL_0) exp_sel = c;
      chk_ctrl();
      c = exp_sel + 3'h3;
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b10, exp_sel});
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, c});
      if (lvl == LEVEL_0) exp_sel = c;
      chk_ctrl();
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b11, exp_sel});
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, 3'h1});
      exp_sel = 3'h1;
      exp_en = (lvl == LEVEL_2);
      chk_ctrl();
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rdata[2:0], {exp_en, lvl})
      // Commit on the last open edge, then one edge too late.
      for (int g = 1; g <= 2; g++) begin
        c = 3'($urandom % 8);
        apb(1'b1, OFS_CONTROL, {27'h0, 2'b11, exp_sel});
        exp_en = 1'b1;
        repeat (g) @(posedge sys_clk);
        apb(1'b1, OFS_CONTROL, {27'h0, 2'b00, c});
        if (g == 1 || lvl == LEVEL_0) exp_sel = c;
        if (g == 1 && lvl != LEVEL_2) exp_en = 1'b0;
        chk_ctrl();
      end
      apb(1'b0, 8'h0c, 32'h0);
      `CHK({rerr, rdata}, {1'b1, 32'h0})
      apb(1'b1, OFS_CONTROL, {27'h0, 2'b01, exp_sel});
      apb(1'b1, OFS_RESTART, 32'h0);
      t = timeout_sys(exp_sel);
      for (k = 0; k < t + 20 && wd_reset_req !== 1'b1; k++)
        @(posedge sys_clk);
      `CHK(k >= t - 9 && k <= t, 1'b1)
      @(posedge sys_clk);
      `CHK(wd_reset_req, 1'b0)
    end
    final_report();
  end
endmodule : testbench
